// file: verilog/video_switch.sv
// Operation
// - Select-input command makes latched switch value the active input.
// - Switch value beyond valid input count leaves active input unchanged.
// - Switched capture writes to one of four destinations by switch value.
// - Absent selected destination: capture completes without writing data.
// - Reject if all destinations absent or present size mismatches.
// - Strobe pulses chosen output when video reaches configured line.
// - Field select is first, second, either, or zero meaning off.
// - Strobe repeats every matching field until zero field select.
// - Target lines 1 to 512 accepted; fields up to 288 guaranteed.
// - Strobe setup takes effect at once, beside pending queued work.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
module video_switch
   import video_switch_pkg::*;
#(
   parameter int NUM_INPUTS = 4,
   parameter int N_STROBE = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic event_done,
   input wire logic [3:0] event_switch,
   output logic [3:0] active_input,
   output logic cap_start,
   output logic [1:0] cap_dest,
   output logic cap_active,
   input wire logic cap_done,
   input wire logic vid_field,
   input wire logic vid_hsync,
   input wire logic vid_vsync,
   output logic [N_STROBE-1:0] strobe
);

   initial begin
      if (NUM_INPUTS < 1 || NUM_INPUTS > 16) begin
         $error("video_switch: NUM_INPUTS must be 1..16");
      end
      if (N_STROBE < 1 || N_STROBE > 16) begin
         $error("video_switch: N_STROBE must be 1..16");
      end
   end

   typedef enum logic [0:0] {
      CAP_IDLE,
      CAP_RUN
   } cap_state_t;

   // Register state
   logic [3:0] switch_q;
   logic [3:0] input_q;
   logic [3:0] present_q;
   logic [31:0] cap_size_q;
   logic [31:0] dest_size_q [NUM_DEST];
   strobe_cfg_t strobe_q;
   logic done_q;
   logic reject_q;
   logic cfg_err_q;
   logic skipped_q;
   cap_state_t state_q;
   cap_state_t state_d;
   logic cap_start_q;
   logic [1:0] cap_dest_q;
   logic [31:0] prdata_q;
   logic pslverr_q;

   // Synchroniser and edge stages for the video pins
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [2:0] sync3_q;

   // APB decode
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire rd = access && !pwrite;
   wire hit_cmd = (paddr == CMD_OFFSET);
   wire hit_switch = (paddr == SWITCH_OFFSET);
   wire hit_input = (paddr == INPUT_OFFSET);
   wire hit_present = (paddr == DEST_PRESENT_OFFSET);
   wire hit_cap_size = (paddr == CAP_SIZE_OFFSET);
   wire hit_status = (paddr == STATUS_OFFSET);
   wire hit_strobe = (paddr == STROBE_OFFSET);
   wire hit_dest = (paddr[7:4] == DEST_SIZE_BASE[7:4]) &&
      (32'(paddr[3:0]) < 32'(NUM_DEST * 4)) && (paddr[1:0] == 2'h0);
   wire [1:0] dest_idx = paddr[3:2];
   wire mapped = hit_cmd || hit_switch || hit_input || hit_present ||
      hit_cap_size || hit_status || hit_strobe || hit_dest;

   // Command strobes; writes to CMD act only in the access cycle
   wire cmd_select = wr && hit_cmd && pwdata[CMD_SELECT_BIT];
   wire cmd_capture = wr && hit_cmd && pwdata[CMD_CAPTURE_BIT];

   // Input switch validity; values are zero-based input indices
   wire switch_valid = (32'(switch_q) < 32'(NUM_INPUTS));

   // Destination checks over all four frames
   logic [NUM_DEST-1:0] size_bad;
   genvar i;
   generate
      for (i = 0; i < NUM_DEST; i++) begin : g_chk
         assign size_bad[i] = present_q[i] &&
            (dest_size_q[i] != cap_size_q);
      end
   endgenerate
   wire none_present = (present_q == 4'h0);
   wire cap_reject = none_present || (size_bad != '0);
   wire [1:0] sel_dest = switch_q[1:0];
   wire dest_absent = !present_q[sel_dest];

   // Capture flow decisions; launch, skip and fail only when idle, busy reject while running
   wire cap_go = cmd_capture && (state_q == CAP_IDLE);
   wire cap_busy_req = cmd_capture && (state_q != CAP_IDLE);
   wire cap_fail = cap_go && cap_reject;
   wire cap_skip = cap_go && !cap_reject && dest_absent;
   wire cap_launch = cap_go && !cap_reject && !dest_absent;
   wire cap_finish = (state_q == CAP_RUN) && cap_done;

   // Strobe setup checks: zero field always allowed to disable
   wire [1:0] new_fsel = pwdata[STROBE_FIELD_LSB +: 2];
   wire [STROBE_LINE_W-1:0] new_line =
      pwdata[STROBE_LINE_LSB +: STROBE_LINE_W];
   wire [STROBE_OUT_W-1:0] new_out = pwdata[STROBE_OUT_LSB +: STROBE_OUT_W];
   wire line_ok = (new_line >= MIN_LINE) && (new_line <= MAX_LINE);
   wire out_ok = (32'(new_out) < 32'(N_STROBE));
   wire strobe_wr = wr && hit_strobe;
   wire strobe_ok = (new_fsel == FIELD_OFF) || (line_ok && out_ok);

   // Status clear mask, write one to clear
   wire clr_done = wr && hit_status && pwdata[STATUS_DONE_BIT];
   wire clr_reject = wr && hit_status && pwdata[STATUS_REJECT_BIT];
   wire clr_cfg = wr && hit_status && pwdata[STATUS_CFG_ERR_BIT];
   wire clr_skip = wr && hit_status && pwdata[STATUS_SKIPPED_BIT];

   // Read mux
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_switch) begin
         rd_mux[3:0] = switch_q;
      end else if (hit_input) begin
         rd_mux[3:0] = input_q;
      end else if (hit_present) begin
         rd_mux[3:0] = present_q;
      end else if (hit_cap_size) begin
         rd_mux = cap_size_q;
      end else if (hit_dest) begin
         rd_mux = dest_size_q[dest_idx];
      end else if (hit_status) begin
         rd_mux[STATUS_BUSY_BIT] = (state_q == CAP_RUN);
         rd_mux[STATUS_DONE_BIT] = done_q;
         rd_mux[STATUS_REJECT_BIT] = reject_q;
         rd_mux[STATUS_CFG_ERR_BIT] = cfg_err_q;
         rd_mux[STATUS_SKIPPED_BIT] = skipped_q;
      end else if (hit_strobe) begin
         rd_mux[STROBE_LINE_LSB +: STROBE_LINE_W] = strobe_q.line;
         rd_mux[STROBE_FIELD_LSB +: 2] = strobe_q.fsel;
         rd_mux[STROBE_OUT_LSB +: STROBE_OUT_W] = strobe_q.out_sel;
      end
   end

   // Zero-wait slave; error flagged only for unmapped addresses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= (psel && !penable && !pwrite) ? rd_mux : prdata_q;
         pslverr_q <= psel && !penable && !mapped;
      end
   end
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q && access;

   // Switch value follows the last completed event wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_q <= SWITCH_RESET;
      end else if (event_done) begin
         switch_q <= event_switch;
      end
   end

   // Active input update; out of range value is a no-op
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_q <= 4'h0;
      end else if (cmd_select && switch_valid) begin
         input_q <= switch_q;
      end
   end
   assign active_input = input_q;

   // Destination setup registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         present_q <= DEST_PRESENT_RESET;
         cap_size_q <= CAP_SIZE_RESET;
      end else begin
         if (wr && hit_present) begin
            present_q <= pwdata[3:0];
         end
         if (wr && hit_cap_size) begin
            cap_size_q <= pwdata;
         end
      end
   end

   generate
      for (i = 0; i < NUM_DEST; i++) begin : g_dest
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dest_size_q[i] <= CAP_SIZE_RESET;
            end else if (wr && hit_dest && dest_idx == 2'(i)) begin
               dest_size_q[i] <= pwdata;
            end
         end
      end
   endgenerate

   // Capture state machine
   always_comb begin
      state_d = state_q;
      case (state_q)
         CAP_IDLE: begin
            if (cap_launch) begin
               state_d = CAP_RUN;
            end
         end
         CAP_RUN: begin
            if (cap_done) begin
               state_d = CAP_IDLE;
            end
         end
         default: begin
            state_d = CAP_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= CAP_IDLE;
         cap_start_q <= 1'b0;
         cap_dest_q <= 2'h0;
      end else begin
         state_q <= state_d;
         cap_start_q <= cap_launch;
         if (cap_launch) begin
            cap_dest_q <= sel_dest;
         end
      end
   end
   assign cap_start = cap_start_q;
   assign cap_dest = cap_dest_q;
   assign cap_active = (state_q == CAP_RUN);

   // Sticky status; a set in the same cycle as a clear wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
         reject_q <= 1'b0;
         cfg_err_q <= 1'b0;
         skipped_q <= 1'b0;
      end else begin
         done_q <= (cap_finish || cap_skip) || (done_q && !clr_done);
         reject_q <= (cap_fail || cap_busy_req) ||
            (reject_q && !clr_reject);
         cfg_err_q <= (strobe_wr && !strobe_ok) || (cfg_err_q && !clr_cfg);
         skipped_q <= cap_skip || (skipped_q && !clr_skip);
      end
   end

   // Strobe setup bypasses the capture queue entirely
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_q <= '{fsel: FIELD_OFF, line: MIN_LINE, out_sel: '0};
      end else if (strobe_wr && strobe_ok) begin
         strobe_q <= '{fsel: new_fsel, line: new_line,
            out_sel: new_out};
      end
   end

   // Two flops on each pin, a third only for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sync3_q <= 3'h0;
      end else begin
         sync1_q <= {vid_vsync, vid_hsync, vid_field};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // Field begins on rising vsync, lines on rising hsync
   video_timing_t vid;
   assign vid.field = sync2_q[0];
   assign vid.line_pulse = sync2_q[1] && !sync3_q[1];
   assign vid.field_start = sync2_q[2] && !sync3_q[2];

   line_strobe_gen #(
      .N_OUT(N_STROBE)
   ) u_strobe (
      .pclk(pclk),
      .presetn(presetn),
      .vid(vid),
      .cfg(strobe_q),
      .strobe(strobe)
   );

endmodule

// file: verilog/video_switch_pkg.sv
package video_switch_pkg;

   // Register byte offsets on the APB
   localparam logic [7:0] CMD_OFFSET = 8'h00;
   localparam logic [7:0] SWITCH_OFFSET = 8'h04;
   localparam logic [7:0] INPUT_OFFSET = 8'h08;
   localparam logic [7:0] DEST_PRESENT_OFFSET = 8'h0c;
   localparam logic [7:0] CAP_SIZE_OFFSET = 8'h10;
   localparam logic [7:0] DEST_SIZE_BASE = 8'h20;
   localparam logic [7:0] STATUS_OFFSET = 8'h30;
   localparam logic [7:0] STROBE_OFFSET = 8'h34;

   // Command register bits, write one to issue
   localparam int CMD_SELECT_BIT = 0;
   localparam int CMD_CAPTURE_BIT = 1;

   // Status register bits
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_DONE_BIT = 1;
   localparam int STATUS_REJECT_BIT = 2;
   localparam int STATUS_CFG_ERR_BIT = 3;
   localparam int STATUS_SKIPPED_BIT = 4;

   // Strobe configuration fields
   localparam int STROBE_LINE_LSB = 0;
   localparam int STROBE_LINE_W = 10;
   localparam int STROBE_FIELD_LSB = 16;
   localparam int STROBE_OUT_LSB = 24;
   localparam int STROBE_OUT_W = 4;

   // Size fields: width low half, height high half
   localparam int SIZE_W_LSB = 0;
   localparam int SIZE_H_LSB = 16;

   // Field select encodings
   localparam logic [1:0] FIELD_OFF = 2'h0;
   localparam logic [1:0] FIRST_FIELD_SELECT = 2'h1;
   localparam logic [1:0] SECOND_FIELD_SELECT = 2'h2;
   localparam logic [1:0] EITHER_FIELD_SELECT = 2'h3;

   // Line limits
   localparam logic [9:0] MIN_LINE = 10'h001;
   localparam logic [9:0] MAX_LINE = 10'h200;
   localparam int GUARANTEED_FIELD_LINES = 288;

   // Reset values
   localparam logic [31:0] CAP_SIZE_RESET = 32'h0000_0000;
   localparam logic [3:0] DEST_PRESENT_RESET = 4'h0;
   localparam logic [3:0] SWITCH_RESET = 4'h0;

   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int STROBE_PULSE_NS = 100;
   localparam int STROBE_PULSE_CYC =
      (STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int NUM_DEST = 4;

   // Video timing events after synchronisation
   typedef struct packed {
      logic field;
      logic line_pulse;
      logic field_start;
   } video_timing_t;

   // Line-synchronous strobe setup
   typedef struct packed {
      logic [1:0] fsel;
      logic [STROBE_LINE_W-1:0] line;
      logic [STROBE_OUT_W-1:0] out_sel;
   } strobe_cfg_t;

endpackage

// file: verilog/line_strobe_gen.sv
module line_strobe_gen
   import video_switch_pkg::*;
#(
   parameter int N_OUT = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input video_timing_t vid,
   input strobe_cfg_t cfg,
   output logic [N_OUT-1:0] strobe
);

   initial begin
      if (N_OUT < 1 || N_OUT > 16) begin
         $error("line_strobe_gen: N_OUT must be 1..16");
      end
   end

   logic [STROBE_LINE_W-1:0] line_q;
   logic field_q;
   logic [7:0] pulse_q;
   logic [STROBE_OUT_W-1:0] sel_q;
   logic [N_OUT-1:0] strobe_q;
   wire field_match;
   wire hit;

   // Field filter; off never matches
   assign field_match = (cfg.fsel == EITHER_FIELD_SELECT) ||
      (cfg.fsel == FIRST_FIELD_SELECT && !field_q) ||
      (cfg.fsel == SECOND_FIELD_SELECT && field_q);
   assign hit = vid.line_pulse && !vid.field_start && field_match &&
      (line_q == cfg.line);

   // Line counter restarts at 1 each field, saturates to stay safe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_q <= MIN_LINE;
         field_q <= 1'b0;
      end else if (vid.field_start) begin
         line_q <= MIN_LINE;
         field_q <= vid.field;
      end else if (vid.line_pulse && line_q != '1) begin
         line_q <= line_q + 1'b1;
      end
   end

   // Pulse stretcher; a new hit restarts the pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_q <= 8'h00;
         sel_q <= '0;
      end else if (hit) begin
         pulse_q <= 8'(STROBE_PULSE_CYC);
         sel_q <= cfg.out_sel;
      end else if (pulse_q != 8'h00) begin
         pulse_q <= pulse_q - 1'b1;
      end
   end

   // One flop per output line
   genvar i;
   generate
      for (i = 0; i < N_OUT; i++) begin : g_out
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               strobe_q[i] <= 1'b0;
            end else begin
               strobe_q[i] <= (pulse_q != 8'h00) &&
                  (sel_q == STROBE_OUT_W'(i));
            end
         end
      end
   endgenerate

   assign strobe = strobe_q;

endmodule

// file: bench/video_switch_chk.sv
module video_switch_chk
   import video_switch_pkg::*;
#(
   parameter int NUM_INPUTS = 4,
   parameter int N_STROBE = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic event_done,
   input wire logic [3:0] event_switch,
   input wire logic [3:0] active_input,
   input wire logic cap_start,
   input wire logic [1:0] cap_dest,
   input wire logic cap_active,
   input wire logic cap_done,
   input wire logic [N_STROBE-1:0] strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0] sw_q;
   logic [5:0] hi_q;
   logic [6:0] off_q;
   wire wr = psel && penable && pwrite;
   wire stb_wr = wr && paddr == STROBE_OFFSET;
   // Shadow switch, pulse length and time since strobing was turned off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_q <= SWITCH_RESET;
         hi_q <= 6'h00;
         off_q <= 7'h00;
      end else begin
         if (event_done)
            sw_q <= event_switch;
         hi_q <= |strobe ? hi_q + 6'h01 : 6'h00;
         if (stb_wr)
            off_q <= pwdata[17:16] == FIELD_OFF ? 7'h00 : 7'h7f;
         else if (off_q < 7'h40)
            off_q <= off_q + 7'h01;
      end
   end
   sequence sel_cmd;
      wr && paddr == CMD_OFFSET && pwdata[CMD_SELECT_BIT];
   endsequence
   sequence launch;
      cap_start ##1 !cap_start && cap_active;
   endsequence
   a_select_valid: assert property ((sel_cmd ##0 sw_q < NUM_INPUTS) |=>
      active_input == $past(sw_q)) else $error("active input not taken");
   a_select_invalid: assert property ((sel_cmd ##0 sw_q >= NUM_INPUTS) |=>
      $stable(active_input)) else $error("active input changed");
   a_launch_pulse: assert property (cap_start |-> launch)
      else $error("capture launch not one pulse");
   a_launch_dest: assert property (cap_start |-> cap_dest == sw_q[1:0])
      else $error("capture destination wrong");
   a_capture_end: assert property (cap_active && cap_done |=> !cap_active)
      else $error("capture still running");
   a_pulse_width: assert property ($fell(|strobe) |->
      hi_q == STROBE_PULSE_CYC) else $error("strobe pulse width wrong");
   a_strobe_off: assert property (off_q == 7'h40 |-> strobe == '0)
      else $error("strobe while disabled");
   a_unmapped_err: assert property (psel && penable && paddr == 8'h14 |->
      pslverr) else $error("unmapped access not flagged");
endmodule

bind video_switch video_switch_chk #(.NUM_INPUTS(NUM_INPUTS),
   .N_STROBE(N_STROBE)) video_switch_chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pslverr(pslverr), .event_done(event_done),
   .event_switch(event_switch), .active_input(active_input),
   .cap_start(cap_start), .cap_dest(cap_dest), .cap_active(cap_active),
   .cap_done(cap_done), .strobe(strobe));

// file: bench/video_source.sv
module video_source #(
   parameter int LINES = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cap_start,
   input wire logic slow,
   output logic cap_done,
   output logic vid_field,
   output logic vid_hsync,
   output logic vid_vsync
);
   timeunit 1ns;
   timeprecision 1ps;
   int pos;
   int wait_c;
   // Free-running fields; field level settles well before the field start
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos <= 0;
         vid_field <= 1'b0;
         vid_vsync <= 1'b0;
         vid_hsync <= 1'b0;
      end else begin
         pos <= pos == 16 * (LINES + 2) - 1 ? 0 : pos + 1;
         if (pos == 0)
            vid_field <= !vid_field;
         vid_vsync <= pos >= 8 && pos < 12;
         vid_hsync <= pos >= 16 && pos < 16 * (LINES + 1) && pos % 16 < 4;
      end
   end
   // Capture engine, prompt or slow as the bench asks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_c <= 0;
         cap_done <= 1'b0;
      end else begin
         cap_done <= wait_c == 1;
         if (cap_start)
            wait_c <= slow ? 2000 : 5;
         else if (wait_c > 0)
            wait_c <= wait_c - 1;
      end
   end
endmodule

// file: bench/video_switch_tb.sv
module video_switch_tb;
   import video_switch_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NUM_IN = 4;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 0, penable = 0, pwrite = 0, event_done = 0, slow = 0, slv;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, rnd = 32'h2b1c_db75;
   logic [3:0] event_switch = '0, active_input, strobe, st_q = '0;
   logic pready, pslverr, cap_start, cap_active, cap_done;
   logic vid_field, vid_hsync, vid_vsync;
   logic [1:0] cap_dest;
   int failures = 0, tests_run = 0, cyc = 0, starts = 0;
   int sw_m = 0, act_m = 0, pres_m = 0, csz = 0;
   int dsz[4] = '{0, 0, 0, 0};
   int rises[4];
   int cf[4] = '{3, 1, 2, 0};
   int ln[4] = '{1, 8, 2, 5};
   int ot[4] = '{0, 1, 3, 2};
   int cl[4] = '{0, 513, 512, 0};
   int ce[4] = '{8, 8, 0, 0};
   always #2.5 pclk = ~pclk;
   video_switch video_switch_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .event_done(event_done), .event_switch(event_switch),
      .active_input(active_input), .cap_start(cap_start),
      .cap_dest(cap_dest), .cap_active(cap_active), .cap_done(cap_done),
      .vid_field(vid_field), .vid_hsync(vid_hsync), .vid_vsync(vid_vsync),
      .strobe(strobe));
   video_source video_source_i (.pclk(pclk), .presetn(presetn),
      .cap_start(cap_start), .slow(slow), .cap_done(cap_done),
      .vid_field(vid_field), .vid_hsync(vid_hsync), .vid_vsync(vid_vsync));
   task automatic conclude();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Strobe rises, launches and the hang limit
   always @(posedge pclk) begin
      st_q <= strobe;
      for (int i = 0; i < 4; i++)
         if (strobe[i] === 1'b1 && st_q[i] === 1'b0)
            rises[i]++;
      if (cap_start === 1'b1)
         starts++;
      cyc++;
      if (cyc == 20000) begin
         failures++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Capture outcome from present map, sizes and switch value
   function automatic int cap_exp();
      if (pres_m == 0)
         return 4;
      for (int i = 0; i < 4; i++)
         if (pres_m[i] && dsz[i] != csz)
            return 4;
      return pres_m[sw_m % 4] ? 2 : 'h12;
   endfunction
   // One APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= 32'(d);
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic evt(input logic [3:0] v);
      @(posedge pclk);
      event_done <= 1'b1;
      event_switch <= v;
      @(posedge pclk);
      event_done <= 1'b0;
      sw_m = v;
   endtask
   // Poll until idle, compare status, then clear it
   task automatic wait_idle(input int e);
      int n;
      n = 0;
      do begin
         apb(0, STATUS_OFFSET, 0);
         n++;
      end while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 1000);
      chk("status", e, rd);
      apb(1, STATUS_OFFSET, 'h1f);
   endtask
   task automatic cap();
      apb(1, CMD_OFFSET, 2);
      wait_idle(cap_exp());
   endtask
   // Count rises over four whole fields, two of each kind
   task automatic window(input int f, input int l, input int o);
      apb(1, STROBE_OFFSET, l | f << 16 | o << 24);
      @(posedge vid_vsync);
      rises = '{0, 0, 0, 0};
      repeat (4) @(posedge vid_vsync);
      for (int i = 0; i < 4; i++)
         chk("rises", i != o ? 0 : f == 3 ? 4 : f == 0 ? 0 : 2, rises[i]);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, SWITCH_OFFSET, 0);
      chk("switch reset", 0, rd);
      apb(0, CAP_SIZE_OFFSET, 0);
      chk("size reset", 0, rd);
      apb(0, 8'h14, 0);
      chk("unmapped", 1, slv);
      // Random switch values, with both sides of the input count
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         evt(i == 0 ? 4'(NUM_IN) : i == 1 ? 4'(NUM_IN - 1) : rnd[3:0]);
         apb(0, SWITCH_OFFSET, 0);
         chk("switch", sw_m, rd);
         apb(1, CMD_OFFSET, 1);
         if (sw_m < NUM_IN)
            act_m = sw_m;
         // Let the select write settle before looking at the output
         @(negedge pclk);
         chk("active", act_m, active_input);
      end
      cap();
      csz = 'h00f0_0140;
      dsz[1] = csz;
      dsz[3] = 'h00f0_0100;
      pres_m = 'ha;
      apb(1, CAP_SIZE_OFFSET, csz);
      apb(1, DEST_SIZE_BASE + 8'h04, dsz[1]);
      apb(1, DEST_SIZE_BASE + 8'h0c, dsz[3]);
      apb(1, DEST_PRESENT_OFFSET, pres_m);
      cap();
      dsz[3] = csz;
      apb(1, DEST_SIZE_BASE + 8'h0c, dsz[3]);
      evt(2);
      cap();
      chk("launches", 0, starts);
      evt(1);
      cap();
      chk("dest", 1, cap_dest);
      slow <= 1'b1;
      evt(3);
      apb(1, CMD_OFFSET, 2);
      apb(1, CMD_OFFSET, 2);
      chk("dest", 3, cap_dest);
      chk("busy", 1, cap_active);
      for (int i = 0; i < 4; i++)
         window(cf[i], ln[i], ot[i]);
      wait_idle(6);
      for (int i = 0; i < 4; i++) begin
         apb(1, STROBE_OFFSET, cl[i] | (i < 3) << 16);
         apb(0, STATUS_OFFSET, 0);
         chk("cfg error", ce[i], rd & 8);
         apb(1, STATUS_OFFSET, 'h1f);
      end
      conclude();
   end
endmodule
